// ### common/rawc_pkg.sv
// Purpose: Shared constants and types of the reset and watchdog control block
// Assumes: 250 MHz system clock, 8-bit register port
// Notes:   Offsets, control field positions, enable/period/vector reset values and timing counts live here
package rawc_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0]  RAWC_ADDR_WDT_CTRL    = 8'h00;
    localparam logic [7:0]  RAWC_ADDR_WDT_STATUS  = 8'h01;

    // Watchdog control register layout
    localparam int          RAWC_CTRL_UNLOCK_BIT  = 4;
    localparam int          RAWC_CTRL_EN_BIT      = 3;
    localparam int          RAWC_CTRL_PER_LSB     = 0;

    // Reset values
    localparam logic        RAWC_EN_RESET         = 1'b0;
    localparam logic [2:0]  RAWC_PER_RESET        = 3'h0;
    localparam logic [15:0] RAWC_RESET_VECTOR     = 16'h0000;

    // Timed sequence window, in system clock cycles
    localparam logic [2:0]  RAWC_UNLOCK_CYCLES    = 3'h4;

    // Reset stretch time, two fuse-selected choices
    localparam int          RAWC_CLK_PERIOD_PS    = 4000;
    localparam int          RAWC_STRETCH_SHORT_NS = 4000;
    localparam int          RAWC_STRETCH_LONG_NS  = 16000;
    localparam logic [11:0] RAWC_STRETCH_SHORT_CYC =
        12'((RAWC_STRETCH_SHORT_NS * 1000 + RAWC_CLK_PERIOD_PS - 1)
            / RAWC_CLK_PERIOD_PS);
    localparam logic [11:0] RAWC_STRETCH_LONG_CYC =
        12'((RAWC_STRETCH_LONG_NS * 1000 + RAWC_CLK_PERIOD_PS - 1)
            / RAWC_CLK_PERIOD_PS);
    localparam int          RAWC_STRETCH_SEL_BIT  = 0;

    // Watchdog time-out, oscillator cycles at period code 000
    localparam int          RAWC_WDT_BASE_CYCLES  = 16384;
    localparam int          RAWC_WDT_CNT_W        = 22;

    typedef enum logic [1:0] {
        RAWC_ST_HOLD    = 2'b00,
        RAWC_ST_STRETCH = 2'b01,
        RAWC_ST_RUN     = 2'b11
    } rawc_rst_state_t;

    typedef enum logic [1:0] {
        RAWC_LVL0 = 2'b00,
        RAWC_LVL1 = 2'b01,
        RAWC_LVL2 = 2'b10
    } rawc_level_t;

endpackage

// ### common/rawc_reset_if.sv
// Purpose: Carries the combined reset request and its released level
// Assumes: Request is an asynchronous active-low level
// Notes:   Joins the top module and the reset synchroniser
`timescale 1ns/1ps
`default_nettype none
interface rawc_reset_if;
    logic req_n;
    logic rel_n;
    modport src  (output req_n, input rel_n);
    modport sync (input req_n, output rel_n);
endinterface
`default_nettype wire

// ### hw/rawc_reset_sync.sv
// Purpose: Asserts reset at once, releases it on the system clock
// Assumes: Request may change with no clock running
// Notes:   Two stages; the first is read only by the second
`timescale 1ns/1ps
`default_nettype none
module rawc_reset_sync (
    input  wire logic  clk_sys,
    rawc_reset_if.sync rif
);
    typedef struct packed {
        logic [1:0] stage;
    } rawc_sync_state_t;

    rawc_sync_state_t sync_q;
    rawc_sync_state_t sync_d;

    always_comb begin
        sync_d = sync_q;
        sync_d.stage = {sync_q.stage[0], 1'b1};
    end

    // Clearing needs no clock, so pins fall back even when stopped
    always_ff @(posedge clk_sys or negedge rif.req_n) begin
        if (!rif.req_n) begin
            sync_q <= '0;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign rif.rel_n = sync_q.stage[1];
endmodule
`default_nettype wire

// ### hw/rawc_reset_watchdog.sv
// Purpose: Reset combiner, reset stretcher, bandgap gate and watchdog
// Assumes: Inputs synchronous to clk_sys; fuses static after power-up
// Notes:   Watchdog oscillator arrives as a level and is edge counted
//
// Summary of operation
// - Reset loads initial values, fetch from vector
// - Ports reset asynchronously on any source
// - Stretch reset by fuse-selected delay count
// - Any of five sources asserts reset
// - Scan register one holds reset
// - Supply good starts stretch, loss resets
// - External low pulse resets without clock
// - Enabled brown-out resets, recovery starts stretch
// - Time-out gives one-cycle reset pulse
// - Bandgap on for brown-out, comparator, converter
// - Watchdog counts its own oscillator edges
// - Kick, disable or chip reset clears counter
// - Eight periods; expiry resets the chip
// - Two fuses select safety level
// - Enable bit write one always accepted
// - Level zero: period free, disable sequenced
// - Level one: period and disable sequenced
// - Second write within four cycles applies
// - Unlock bit clears four cycles later
// - Level two: always enabled, period sequenced
// - Period code doubles from base count
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rawc_reset_watchdog #(
    parameter int WDT_BASE_CYCLES = rawc_pkg::RAWC_WDT_BASE_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        power_ok,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        brownout_detector_low,
    input  wire logic        brownout_enable_fuse,
    input  wire logic        scan_reset_reg,
    input  wire logic [3:0]  clock_select_fuses,
    input  wire logic        legacy_compat_fuse,
    input  wire logic        watchdog_always_on_fuse,
    input  wire logic        comparator_bandgap_select,
    input  wire logic        adc_enable,
    input  wire logic        watchdog_kick,
    input  wire logic        wdt_osc,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             cpu_reset_n,
    output logic             io_reset_n,
    output logic      [15:0] reset_vector,
    output logic             bandgap_enable,
    output logic             wdt_reset_pulse
);
    localparam int CW = rawc_pkg::RAWC_WDT_CNT_W;

    typedef struct packed {
        rawc_pkg::rawc_rst_state_t st;
        logic [11:0]               stretch_cnt;
        logic                      sys_rst_n;
        logic [15:0]               vector;
        logic                      bandgap_en;
        logic                      en;
        logic [2:0]                per;
        logic [2:0]                unlock_cnt;
        logic [CW-1:0]             wdt_cnt;
        logic                      osc_prev;
        logic                      wdt_pulse;
        logic [7:0]                rdata;
        logic [12:0]               quiet;
    } rawc_state_t;

    rawc_state_t st_q;
    rawc_state_t st_d;

    rawc_reset_if rif ();

    // Fuse decode of the watchdog safety level
    function automatic rawc_pkg::rawc_level_t rawc_level(
        input logic compat,
        input logic always_on
    );
        if (always_on) begin
            return rawc_pkg::RAWC_LVL2;
        end else if (compat) begin
            return rawc_pkg::RAWC_LVL0;
        end
        return rawc_pkg::RAWC_LVL1;
    endfunction

    // Stretch length in system cycles from the clock-select fuses
    function automatic logic [11:0] rawc_stretch_len(input logic [3:0] sel);
        if (sel[rawc_pkg::RAWC_STRETCH_SEL_BIT]) begin
            return rawc_pkg::RAWC_STRETCH_LONG_CYC;
        end
        return rawc_pkg::RAWC_STRETCH_SHORT_CYC;
    endfunction

    // Time-out in oscillator cycles, doubling per code step
    function automatic logic [CW-1:0] rawc_wdt_limit(input logic [2:0] p);
        return CW'(WDT_BASE_CYCLES) << p;
    endfunction

    rawc_pkg::rawc_level_t level;
    logic                  run;
    logic                  any_src;
    logic                  en_eff;
    logic                  unlock_bit;
    logic                  tick;
    logic                  ctrl_wr;
    logic                  open_wr;
    logic [11:0]           stretch_len;
    logic [CW-1:0]         limit;

    // Glitches here only lengthen reset; the release is clocked anyway
    assign rif.req_n = power_ok
                     & ext_reset_pin_n
                     & ~(brownout_enable_fuse & brownout_detector_low)
                     & ~scan_reset_reg
                     & ~st_q.wdt_pulse;

    rawc_reset_sync u_sync (
        .clk_sys (clk_sys),
        .rif     (rif.sync)
    );

    assign level       = rawc_level(legacy_compat_fuse,
                                    watchdog_always_on_fuse);
    assign run         = st_q.sys_rst_n;
    assign any_src     = !rif.rel_n || st_q.wdt_pulse;
    assign en_eff      = st_q.en || (level == rawc_pkg::RAWC_LVL2);
    assign unlock_bit  = (st_q.unlock_cnt != 3'h0);
    assign tick        = wdt_osc && !st_q.osc_prev;
    assign ctrl_wr     = reg_wr && run
                      && (reg_addr == rawc_pkg::RAWC_ADDR_WDT_CTRL);
    assign open_wr     = ctrl_wr
                      && reg_wdata[rawc_pkg::RAWC_CTRL_UNLOCK_BIT]
                      && reg_wdata[rawc_pkg::RAWC_CTRL_EN_BIT];
    assign stretch_len = rawc_stretch_len(clock_select_fuses);
    assign limit       = rawc_wdt_limit(st_q.per);

    always_comb begin
        st_d = st_q;

        // Reset sequencer: hold, then count out the stretch
        case (st_q.st)
            rawc_pkg::RAWC_ST_HOLD: begin
                st_d.sys_rst_n   = 1'b0;
                st_d.stretch_cnt = stretch_len;
                if (!any_src) begin
                    st_d.st = rawc_pkg::RAWC_ST_STRETCH;
                end
            end
            rawc_pkg::RAWC_ST_STRETCH: begin
                if (any_src) begin
                    st_d.st = rawc_pkg::RAWC_ST_HOLD;
                end else if (st_q.stretch_cnt == 12'h001) begin
                    st_d.st        = rawc_pkg::RAWC_ST_RUN;
                    st_d.sys_rst_n = 1'b1;
                end else begin
                    st_d.stretch_cnt = st_q.stretch_cnt - 12'h001;
                end
            end
            rawc_pkg::RAWC_ST_RUN: begin
                if (any_src) begin
                    st_d.st        = rawc_pkg::RAWC_ST_HOLD;
                    st_d.sys_rst_n = 1'b0;
                end
            end
            default: begin
                st_d.st        = rawc_pkg::RAWC_ST_HOLD;
                st_d.sys_rst_n = 1'b0;
            end
        endcase

        if (!run) begin
            // Chip reset puts the watchdog and vector back to initial state
            st_d.en         = rawc_pkg::RAWC_EN_RESET;
            st_d.per        = rawc_pkg::RAWC_PER_RESET;
            st_d.unlock_cnt = 3'h0;
            st_d.wdt_cnt    = '0;
            st_d.wdt_pulse  = 1'b0;
            st_d.vector     = rawc_pkg::RAWC_RESET_VECTOR;
        end else begin
            st_d.wdt_pulse = 1'b0;
            if (unlock_bit) begin
                st_d.unlock_cnt = st_q.unlock_cnt - 3'h1;
            end
            if (open_wr) begin
                // Reopening wins over the countdown
                st_d.unlock_cnt = rawc_pkg::RAWC_UNLOCK_CYCLES;
                st_d.en         = 1'b1;
                if (level == rawc_pkg::RAWC_LVL0) begin
                    st_d.per = reg_wdata[rawc_pkg::RAWC_CTRL_PER_LSB +: 3];
                end
            end else if (ctrl_wr && unlock_bit) begin
                // Second step of the timed sequence closes the window
                st_d.en = reg_wdata[rawc_pkg::RAWC_CTRL_EN_BIT]
                       || (level == rawc_pkg::RAWC_LVL2);
                st_d.per        = reg_wdata[rawc_pkg::RAWC_CTRL_PER_LSB +: 3];
                st_d.unlock_cnt = 3'h0;
            end else if (ctrl_wr) begin
                // Outside the window enabling is free, and at level zero the period too
                if (reg_wdata[rawc_pkg::RAWC_CTRL_EN_BIT]) begin
                    st_d.en = 1'b1;
                end
                if (level == rawc_pkg::RAWC_LVL0) begin
                    st_d.per = reg_wdata[rawc_pkg::RAWC_CTRL_PER_LSB +: 3];
                end
            end

            if (!en_eff || watchdog_kick) begin
                st_d.wdt_cnt = '0;
            end else if (tick) begin
                if (st_q.wdt_cnt == limit - {{(CW-1){1'b0}}, 1'b1}) begin
                    st_d.wdt_cnt   = '0;
                    st_d.wdt_pulse = 1'b1;
                end else begin
                    st_d.wdt_cnt = st_q.wdt_cnt + {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end

        // Read data stand for the one cycle after the strobe
        st_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                rawc_pkg::RAWC_ADDR_WDT_CTRL: begin
                    st_d.rdata[rawc_pkg::RAWC_CTRL_UNLOCK_BIT] = unlock_bit;
                    st_d.rdata[rawc_pkg::RAWC_CTRL_EN_BIT]     = en_eff;
                    st_d.rdata[rawc_pkg::RAWC_CTRL_PER_LSB +: 3] = st_q.per;
                end
                rawc_pkg::RAWC_ADDR_WDT_STATUS: begin
                    st_d.rdata = {6'h00, level};
                end
                default: begin
                    st_d.rdata = 8'h00;
                end
            endcase
        end

        // Cycles since the last reset request, seen only by checks
        if (any_src) begin
            st_d.quiet = 13'h0000;
        end else if (st_q.quiet != 13'h1fff) begin
            st_d.quiet = st_q.quiet + 13'h0001;
        end

        if (!rst_n) begin
            st_d        = '0;
            st_d.vector = rawc_pkg::RAWC_RESET_VECTOR;
            st_d.en     = rawc_pkg::RAWC_EN_RESET;
            st_d.per    = rawc_pkg::RAWC_PER_RESET;
        end

        // Kept live through block reset: a stale edge history fakes a tick
        st_d.osc_prev   = wdt_osc;
        st_d.bandgap_en = brownout_enable_fuse
                        | comparator_bandgap_select
                        | adc_enable;
    end

    always_ff @(posedge clk_sys) begin
        st_q <= st_d;
    end

    assign reg_rdata       = st_q.rdata;
    assign cpu_reset_n     = st_q.sys_rst_n;
    assign io_reset_n      = rif.rel_n;
    assign reset_vector    = st_q.vector;
    assign bandgap_enable  = st_q.bandgap_en;
    assign wdt_reset_pulse = st_q.wdt_pulse;

    default clocking rawc_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    AST_IO_RESET_NOW:
    assert property (!rif.req_n |-> !io_reset_n)
        else $error("port reset not asserted with request");

    AST_SRC_HOLDS_CPU:
    assert property (any_src |=> !cpu_reset_n)
        else $error("reset source did not hold cpu reset");

    AST_STRETCH_LEN:
    assert property ($rose(cpu_reset_n)
                     |-> st_q.quiet == {1'b0, stretch_len} + 13'h0001)
        else $error("reset stretch length wrong");

    AST_PULSE_ONE_CYCLE:
    assert property (wdt_reset_pulse |=> !wdt_reset_pulse && !cpu_reset_n)
        else $error("watchdog pulse not one cycle or no reset");

    AST_TIMEOUT_FIRES:
    assert property (run && en_eff && tick && !watchdog_kick
                     && st_q.wdt_cnt == limit - {{(CW-1){1'b0}}, 1'b1}
                     |=> wdt_reset_pulse)
        else $error("watchdog expiry gave no pulse");

    AST_KICK_CLEARS:
    assert property (run && watchdog_kick |=> st_q.wdt_cnt == '0)
        else $error("watchdog kick did not clear counter");

    AST_BANDGAP:
    assert property (##1 bandgap_enable == $past(brownout_enable_fuse
                     | comparator_bandgap_select | adc_enable))
        else $error("bandgap enable mismatch");

    AST_ENABLE_FREE:
    assert property (ctrl_wr && reg_wdata[rawc_pkg::RAWC_CTRL_EN_BIT]
                     |=> en_eff)
        else $error("enable write refused");

    AST_NO_FREE_DISABLE:
    assert property (ctrl_wr && !unlock_bit && en_eff
                     && !reg_wdata[rawc_pkg::RAWC_CTRL_EN_BIT] |=> en_eff)
        else $error("watchdog disabled without timed sequence");

    AST_UNLOCK_CLOSES:
    assert property (open_wr ##1 (run && !reg_wr) [*4]
                     |=> !unlock_bit && $past(unlock_bit))
        else $error("unlock window not four cycles");

    AST_WINDOW_PERIOD:
    assert property (ctrl_wr && unlock_bit
                     && !reg_wdata[rawc_pkg::RAWC_CTRL_UNLOCK_BIT]
                     |=> st_q.per == $past(reg_wdata[2:0]))
        else $error("window write did not set period");

    AST_LEVEL2_ON:
    assert property (run && level == rawc_pkg::RAWC_LVL2 && tick
                     && !watchdog_kick
                     |=> st_q.wdt_cnt != '0 || wdt_reset_pulse)
        else $error("watchdog not counting in level two");

    COV_TIMEOUT:
    cover property (wdt_reset_pulse);

    COV_SEQ_DISABLE:
    cover property (open_wr ##[1:4] (ctrl_wr && unlock_bit
                    && !reg_wdata[rawc_pkg::RAWC_CTRL_EN_BIT]) ##1 !en_eff);

    COV_RELEASE:
    cover property ($rose(cpu_reset_n));
endmodule
`default_nettype wire

// ### verif/rawc_far_model.sv
// Purpose: Far side model: supply detectors, reset pin, scan bit, osc
// Assumes: Requests come from the bench at clk_sys rising edges
// Notes:   The oscillator runs free; one rising edge every 4 clk_sys
`timescale 1ns/1ps
`default_nettype none
module rawc_far_model #(
    parameter int PIN_LOW_CYC = 8
) (
    input  wire logic clk_sys,
    input  wire logic pin_req,
    input  wire logic supply_fail,
    input  wire logic brown_fail,
    input  wire logic scan_req,
    output logic      power_ok,
    output logic      ext_reset_pin_n,
    output logic      brownout_detector_low,
    output logic      scan_reset_reg,
    output logic      wdt_osc
);
    int         pin_cnt = 0;
    logic [1:0] osc_q   = 2'h0;

    // A pin pulse always outlasts the minimum width, so it must count
    always @(posedge clk_sys) begin
        if (pin_req)
            pin_cnt <= PIN_LOW_CYC;
        else if (pin_cnt > 0)
            pin_cnt <= pin_cnt - 1;
        osc_q <= osc_q + 2'h1;
    end

    // Pin falls with the request itself, not one edge later
    assign ext_reset_pin_n       = (pin_cnt == 0) && !pin_req;
    assign power_ok              = ~supply_fail;
    assign brownout_detector_low = brown_fail;
    assign scan_reset_reg        = scan_req;
    assign wdt_osc               = osc_q[1];
endmodule
`default_nettype wire

// ### verif/rawc_reset_watchdog_tb.sv
// Purpose: Self-checking bench of the reset and watchdog block
// Assumes: Watchdog base count shortened to 16 oscillator cycles
// Notes:   Stretch length is checked inside a small window only
`timescale 1ns/1ps
`default_nettype none
module rawc_reset_watchdog_tb;
    localparam int BASE = 16;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        bo_fuse = 1'b0;
    logic [3:0]  cs_fuse = 4'h0;
    logic        compat = 1'b0;
    logic        always_on = 1'b0;
    logic        cmp_sel = 1'b0;
    logic        adc_en = 1'b0;
    logic        kick = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  src_v = 4'h0;
    logic [7:0]  reg_rdata;
    logic        cpu_reset_n;
    logic        io_reset_n;
    logic [15:0] reset_vector;
    logic        bandgap_enable;
    logic        wdt_reset_pulse;
    logic        power_ok;
    logic        pin_n;
    logic        bo_low;
    logic        scan_bit;
    logic        wdt_osc;
    logic [7:0]  d;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cyc_cnt = 0;
    int          pulse_cnt = 0;
    int          stretch = 1000;
    int          n;
    int          p;

    rawc_far_model far (.clk_sys, .pin_req(src_v[1]),
        .supply_fail(src_v[0]), .brown_fail(src_v[2]),
        .scan_req(src_v[3]), .power_ok, .ext_reset_pin_n(pin_n),
        .brownout_detector_low(bo_low), .scan_reset_reg(scan_bit),
        .wdt_osc);

    rawc_reset_watchdog #(.WDT_BASE_CYCLES(BASE)) dut (.clk_sys, .rst_n,
        .power_ok, .ext_reset_pin_n(pin_n), .brownout_detector_low(bo_low),
        .brownout_enable_fuse(bo_fuse), .scan_reset_reg(scan_bit),
        .clock_select_fuses(cs_fuse), .legacy_compat_fuse(compat),
        .watchdog_always_on_fuse(always_on),
        .comparator_bandgap_select(cmp_sel), .adc_enable(adc_en),
        .watchdog_kick(kick), .wdt_osc, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .cpu_reset_n, .io_reset_n, .reset_vector,
        .bandgap_enable, .wdt_reset_pulse);

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard sized well above the roughly 37k cycles of the run
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        if (wdt_reset_pulse === 1'b1)
            pulse_cnt <= pulse_cnt + 1;
        if (cyc_cnt == 90000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(16'(reg_rdata), 16'(exp));
    endtask

    // Counts edges until the stretched reset lets go
    task automatic wait_rel();
        n = 0;
        while (cpu_reset_n !== 1'b1 && n < 6000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        check(16'(n >= stretch && n <= stretch + 16), 16'h1);
    endtask

    task automatic restart(input logic c, input logic a, input logic l,
                           input logic [7:0] lvl);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        compat <= c;
        always_on <= a;
        cs_fuse <= {3'h0, l};
        stretch = l ? int'(rawc_pkg::RAWC_STRETCH_LONG_CYC)
                    : int'(rawc_pkg::RAWC_STRETCH_SHORT_CYC);
        cyc(3);
        rst_n <= 1'b1;
        wait_rel();
        rd(rawc_pkg::RAWC_ADDR_WDT_STATUS, lvl);
        rd(rawc_pkg::RAWC_ADDR_WDT_CTRL, a ? 8'h08 : 8'h00);
        check(reset_vector, 16'h0000);
    endtask

    task automatic src_test(input int k);
        @(posedge clk_sys);
        src_v[k] <= 1'b1;
        #1 check(16'(io_reset_n), 16'h0);
        cyc(3);
        #1 check(16'(cpu_reset_n), 16'h0);
        @(posedge clk_sys);
        src_v[k] <= 1'b0;
        wait_rel();
    endtask

    initial begin
        restart(1'b0, 1'b0, 1'b0, 8'h01);
        for (int k = 0; k < 4; k++) begin
            bo_fuse <= (k == 2);
            src_test(k);
        end
        bo_fuse <= 1'b0;
        src_v[2] <= 1'b1;
        cyc(5);
        #1 check(16'({io_reset_n, cpu_reset_n}), 16'h3);
        @(posedge clk_sys);
        src_v[2] <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            {bo_fuse, cmp_sel, adc_en} <= 3'(i);
            cyc(3);
            #1 check(16'(bandgap_enable), 16'(i != 0));
        end
        $display("test sources and bandgap done");
        wr(8'h00, 8'h08);
        rd(8'h00, 8'h08);
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h0a);
        rd(8'h00, 8'h08);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00);
        wr(8'h00, 8'h18);
        wr(8'h00, 8'h02);
        rd(8'h00, 8'h02);
        wr(8'h00, 8'h18);
        rd(8'h00, 8'h1a);
        cyc(4);
        rd(8'h00, 8'h0a);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h0a);
        wr(8'h00, 8'h18);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00);
        $display("test level one control done");
        for (int code = 0; code < 8; code++) begin
            wr(8'h00, 8'h18);
            wr(8'h00, 8'h08 | 8'(code));
            n = 0;
            while (wdt_reset_pulse !== 1'b1 && n < 10000) begin
                @(posedge clk_sys);
                #1 n++;
            end
            p = (BASE << code) * 4;
            check(16'(n >= p - 12 && n <= p + 12), 16'h1);
            @(posedge clk_sys);
            #1 check(16'({wdt_reset_pulse, cpu_reset_n}), 16'h0);
            wait_rel();
            rd(8'h00, 8'h00);
        end
        $display("test watchdog periods done");
        restart(1'b1, 1'b0, 1'b0, 8'h00);
        wr(8'h00, 8'h0b);
        rd(8'h00, 8'h0b);
        wr(8'h00, 8'h03);
        rd(8'h00, 8'h0b);
        p = pulse_cnt;
        repeat (15) begin
            @(posedge clk_sys);
            kick <= 1'b1;
            @(posedge clk_sys);
            kick <= 1'b0;
            cyc(98);
        end
        check(16'(pulse_cnt - p), 16'h0);
        wr(8'h00, 8'h18);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00);
        cyc(700);
        check(16'(pulse_cnt - p), 16'h0);
        $display("test level zero done");
        restart(1'b0, 1'b1, 1'b1, 8'h02);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h08);
        wr(8'h00, 8'h18);
        wr(8'h00, 8'h05);
        rd(8'h00, 8'h0d);
        $display("test level two done");
        end_of_test();
    end
endmodule
`default_nettype wire
